/* hdl/pdm_power_ctrl.sv */
// Purpose: Power-down mode control: sleep, software standby and
//          module standby, with the standby control register.
// Assumes: Sleep request, watchdog enable and module stop selects come
//          from logic on the core clock; pins are synchronised here.
// Notes:   Outputs tell each unit whether to hold or to reset.
// Behaviour
// - Any reset returns to normal operation
// - Select bit picks sleep or software standby
// - Select bit refused while watchdog runs
// - Float bit floats ports during standby
// - Float bit refused while watchdog runs
// - Bit 1 gates high interrupt group wake from software standby
// - Bit 0 gates low interrupt group wake from software standby
// - Bit 5 reads 0, bits 4-2 read 1
// - Sleep halts CPU only, rest keeps running
// - Standby stops clock, holds or resets units
// - Module standby stops selected units only
// - Held units keep their state until released
// - Power-on and manual reset inputs exist
// - Sleep and module standby may coexist
`timescale 1ns/100ps
module pdm_power_ctrl
  import pdm_pkg::*;
(
  input  wire logic                   I_CORE_CLK,
  input  wire logic                   I_RESETN,
  input  wire logic                   I_WB_CYC,
  input  wire logic                   I_WB_STB,
  input  wire logic                   I_WB_WE,
  input  wire logic [PDM_ADR_W-1:0]   I_WB_ADR,
  input  wire logic [3:0]             I_WB_SEL,
  input  wire logic [PDM_BUS_DW-1:0]  I_WB_DAT,
  output logic      [PDM_BUS_DW-1:0]  O_WB_DAT,
  output logic                        O_WB_ACK,
  input  wire logic                   I_POWER_ON_RESET_IN_N,
  input  wire logic                   I_MANUAL_RESET_IN_N,
  input  wire logic                   I_NMI,
  input  wire logic [PDM_N_IRQ-1:0]   I_EXTERNAL_INTERRUPT_LINES,
  input  wire logic                   I_SLEEP_EXEC,
  input  wire logic                   I_WATCHDOG_RUN_ENABLE,
  input  wire logic [PDM_N_UNITS-1:0] I_MODULE_STOP,
  output logic                        O_CPU_HALT,
  output logic                        O_CLOCK_GEN_STOP,
  output logic                        O_PORT_FLOAT,
  output logic      [PDM_N_UNITS-1:0] O_UNIT_HOLD,
  output logic      [PDM_N_UNITS-1:0] O_UNIT_RESET
);

  typedef struct packed {
    pdm_mode_e              mode;
    pdm_cause_e             cause;
    logic [7:0]             standby_control;
    logic                   cpu_halt;
    logic                   clk_stop;
    logic                   port_float;
    logic [PDM_N_UNITS-1:0] hold;
    logic [PDM_N_UNITS-1:0] rst;
  } pdm_core_s;

  localparam pdm_core_s PDM_CORE_RESET = '{
    mode:            PDM_NORMAL,
    cause:           PDM_WAKE_NONE,
    standby_control: PDM_SBC_RESET,
    cpu_halt:        1'b0,
    clk_stop:        1'b0,
    port_float:      1'b0,
    hold:            '0,
    rst:             '0
  };

  localparam logic [10:0] PDM_PIN_IDLE = 11'h600;

  pdm_reg_if rif ();

  pdm_core_s            r;
  pdm_core_s            next_r;
  logic [10:0]          pins_sync;
  logic                 por_n;
  logic                 manual_reset_in_n;
  logic                 nmi;
  logic [PDM_N_IRQ-1:0] irq;
  logic [7:0]           wr_val;
  logic                 high_wake;
  logic                 low_wake;
  logic                 sleep_wake;
  logic                 stby_wake;
  logic [PDM_N_UNITS-1:0] mod_stop;

  pdm_wb_slave u_bus (
    .i_clk    (I_CORE_CLK),
    .i_rst_n  (I_RESETN),
    .i_wb_cyc (I_WB_CYC),
    .i_wb_stb (I_WB_STB),
    .i_wb_we  (I_WB_WE),
    .i_wb_adr (I_WB_ADR),
    .i_wb_sel (I_WB_SEL),
    .i_wb_dat (I_WB_DAT),
    .o_wb_dat (O_WB_DAT),
    .o_wb_ack (O_WB_ACK),
    .rif      (rif.bus_side)
  );

  // Reset pins idle high, interrupt lines idle low
  pdm_sync #(
    .W       (11),
    .RST_VAL (PDM_PIN_IDLE)
  ) u_pins (
    .i_clk   (I_CORE_CLK),
    .i_rst_n (I_RESETN),
    .i_async ({I_POWER_ON_RESET_IN_N, I_MANUAL_RESET_IN_N, I_NMI,
               I_EXTERNAL_INTERRUPT_LINES}),
    .o_sync  (pins_sync)
  );

  assign por_n  = pins_sync[10];
  assign manual_reset_in_n = pins_sync[9];
  assign nmi    = pins_sync[8];
  assign irq    = pins_sync[7:0];

  // A gate bit of 0 lets its group release software standby
  assign high_wake = ~r.standby_control[PDM_HIGH_IRQ_GATE_BIT]
                   & (|irq[7:4]);
  assign low_wake  = ~r.standby_control[PDM_LOW_IRQ_GATE_BIT]
                   & (|irq[3:0]);
  assign stby_wake  = nmi | high_wake | low_wake;
  assign sleep_wake = nmi | (|irq);

  // Port and watchdog have no module stop setting
  assign mod_stop = I_MODULE_STOP
                  & (PDM_MST_HOLD_MASK | PDM_MST_RESET_MASK);

  // Read mux; bits above the register read zero in the bus slave
  always_comb begin
    if (rif.addr == PDM_ADDR_STANDBY_CONTROL) begin
      rif.rdata = r.standby_control;
    end else if (rif.addr == PDM_ADDR_STATUS) begin
      rif.rdata = '0;
      rif.rdata[PDM_STAT_MODE_LSB +: 2]  = r.mode;
      rif.rdata[PDM_STAT_CAUSE_LSB +: 2] = r.cause;
      rif.rdata[PDM_STAT_FLOAT_BIT]      = r.port_float;
      rif.rdata[PDM_STAT_WDT_BIT]        = I_WATCHDOG_RUN_ENABLE;
    end else begin
      rif.rdata = '0;
    end
  end

  always_comb begin
    next_r = r;
    wr_val = (rif.wdata & PDM_SBC_WRITABLE) | PDM_SBC_FIXED_ONES;

    // A refused 1 leaves the bit as it was rather than clearing it
    if (I_WATCHDOG_RUN_ENABLE && wr_val[PDM_STANDBY_SELECT_BIT]) begin
      wr_val[PDM_STANDBY_SELECT_BIT] =
        r.standby_control[PDM_STANDBY_SELECT_BIT];
    end
    if (I_WATCHDOG_RUN_ENABLE && wr_val[PDM_PORT_FLOAT_BIT]) begin
      wr_val[PDM_PORT_FLOAT_BIT] =
        r.standby_control[PDM_PORT_FLOAT_BIT];
    end
    if (rif.wr_en && rif.addr == PDM_ADDR_STANDBY_CONTROL) begin
      next_r.standby_control = wr_val;
    end

    case (r.mode)
      PDM_NORMAL: begin
        if (I_SLEEP_EXEC) begin
          if (r.standby_control[PDM_STANDBY_SELECT_BIT]) begin
            next_r.mode = PDM_SW_STANDBY;
          end else begin
            next_r.mode = PDM_SLEEP;
          end
        end
      end
      PDM_SLEEP: begin
        if (sleep_wake) begin
          next_r.mode  = PDM_NORMAL;
          next_r.cause = nmi ? PDM_WAKE_NMI : PDM_WAKE_IRQ;
        end
      end
      PDM_SW_STANDBY: begin
        if (stby_wake) begin
          next_r.mode  = PDM_NORMAL;
          next_r.cause = nmi ? PDM_WAKE_NMI : PDM_WAKE_IRQ;
        end
      end
      default: begin
        next_r.mode = PDM_NORMAL;
      end
    endcase

    // Manual reset only leaves low power; settings survive it
    if (!manual_reset_in_n) begin
      next_r.mode  = PDM_NORMAL;
      next_r.cause = PDM_WAKE_RESET;
    end
    if (!por_n) begin
      next_r       = PDM_CORE_RESET;
      next_r.cause = PDM_WAKE_RESET;
    end

    // Sleep stops the CPU alone; clock, NMI and units keep going
    next_r.cpu_halt = (next_r.mode != PDM_NORMAL);
    next_r.clk_stop = (next_r.mode == PDM_SW_STANDBY);
    next_r.port_float = (next_r.mode == PDM_SW_STANDBY)
      & next_r.standby_control[PDM_PORT_FLOAT_BIT];

    // Module stop applies in every mode, so it combines with sleep
    next_r.hold = mod_stop & PDM_MST_HOLD_MASK;
    next_r.rst  = mod_stop & PDM_MST_RESET_MASK;
    if (next_r.mode == PDM_SW_STANDBY) begin
      next_r.hold = next_r.hold | PDM_SWS_HOLD_MASK;
      next_r.rst  = next_r.rst | PDM_SWS_RESET_MASK;
    end
    // Ports floated are not held at their old level
    if (next_r.port_float) begin
      next_r.hold[PDM_U_PORT] = 1'b0;
    end
    // A unit under reset is not also asked to keep its state
    next_r.hold = next_r.hold & ~next_r.rst;
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      r <= PDM_CORE_RESET;
    end else begin
      r <= next_r;
    end
  end

  assign O_CPU_HALT       = r.cpu_halt;
  assign O_CLOCK_GEN_STOP = r.clk_stop;
  assign O_PORT_FLOAT     = r.port_float;
  assign O_UNIT_HOLD      = r.hold;
  assign O_UNIT_RESET     = r.rst;

endmodule

/* hdl/pdm_sync.sv */
// Purpose: Two-stage synchroniser for pins from outside the core clock.
// Assumes: Each bit is an independent level.
// Notes:   Only the second stage may be read by other logic.
`timescale 1ns/100ps
module pdm_sync
  import pdm_pkg::*;
#(
  parameter int unsigned   W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } pdm_sync_s;

  pdm_sync_s r;
  pdm_sync_s next_r;

  always_comb begin
    next_r        = r;
    next_r.meta   = i_async;
    next_r.stable = r.meta;
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      r <= {RST_VAL, RST_VAL};
    end else begin
      r <= next_r;
    end
  end

  assign o_sync = r.stable;

endmodule

/* hdl/pdm_wb_slave.sv */
// Purpose: Classic Wishbone slave for the power-down registers.
// Assumes: Single cycles; ack comes one cycle after the request.
// Notes:   Unmapped addresses read zero and ignore writes, but still ack.
`timescale 1ns/100ps
module pdm_wb_slave
  import pdm_pkg::*;
(
  input  wire logic                  i_clk,
  input  wire logic                  i_rst_n,
  input  wire logic                  i_wb_cyc,
  input  wire logic                  i_wb_stb,
  input  wire logic                  i_wb_we,
  input  wire logic [PDM_ADR_W-1:0]  i_wb_adr,
  input  wire logic [3:0]            i_wb_sel,
  input  wire logic [PDM_BUS_DW-1:0] i_wb_dat,
  output logic      [PDM_BUS_DW-1:0] o_wb_dat,
  output logic                       o_wb_ack,
  pdm_reg_if.bus_side                rif
);

  typedef struct packed {
    logic                  ack;
    logic [PDM_BUS_DW-1:0] dat;
  } pdm_wb_s;

  pdm_wb_s r;
  pdm_wb_s next_r;
  logic    take;

  // Blocking on the ack cycle keeps one request from being taken twice
  assign take      = i_wb_cyc & i_wb_stb & ~r.ack;
  assign rif.wr_en = take & i_wb_we & i_wb_sel[0];
  assign rif.addr  = i_wb_adr;
  assign rif.wdata = i_wb_dat[7:0];

  always_comb begin
    next_r     = r;
    next_r.ack = take;
    if (take && !i_wb_we) begin
      next_r.dat = {24'h000000, rif.rdata};
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign o_wb_ack = r.ack;
  assign o_wb_dat = r.dat;

endmodule

/* shared/pdm_pkg.sv */
// Purpose: Shared constants and types of the power-down mode controller.
// Assumes: Registers are 8 bits wide, one per aligned 32-bit bus word.
// Notes:   Unit masks tell which units reset and which hold in software standby and under module stop.
package pdm_pkg;

  localparam int unsigned PDM_BUS_DW = 32;
  localparam int unsigned PDM_ADR_W  = 8;

  localparam logic [7:0] PDM_ADDR_STANDBY_CONTROL = 8'h00;
  localparam logic [7:0] PDM_ADDR_STATUS          = 8'h04;

  localparam int unsigned PDM_STANDBY_SELECT_BIT = 7;
  localparam int unsigned PDM_PORT_FLOAT_BIT     = 6;
  localparam int unsigned PDM_HIGH_IRQ_GATE_BIT  = 1;
  localparam int unsigned PDM_LOW_IRQ_GATE_BIT   = 0;

  // Bit 5 reads 0, bits 4..2 read 1, the rest are writable
  localparam logic [7:0] PDM_SBC_RESET      = 8'h1f;
  localparam logic [7:0] PDM_SBC_FIXED_ONES = 8'h1c;
  localparam logic [7:0] PDM_SBC_WRITABLE   = 8'hc3;

  localparam int unsigned PDM_STAT_MODE_LSB  = 0;
  localparam int unsigned PDM_STAT_CAUSE_LSB = 2;
  localparam int unsigned PDM_STAT_FLOAT_BIT = 4;
  localparam int unsigned PDM_STAT_WDT_BIT   = 5;

  localparam int unsigned PDM_N_IRQ   = 8;
  localparam int unsigned PDM_N_UNITS = 13;

  // Unit order: break, dma, transfer, two-wire, serial, converter,
  // multi-function timer, compare timer, debug, trace, ram, port, watchdog
  localparam int unsigned PDM_U_PORT     = 11;
  localparam int unsigned PDM_U_WATCHDOG = 12;

  localparam logic [12:0] PDM_SWS_HOLD_MASK  = 13'h1d01;
  localparam logic [12:0] PDM_SWS_RESET_MASK = 13'h02fe;
  localparam logic [12:0] PDM_MST_HOLD_MASK  = 13'h0500;
  localparam logic [12:0] PDM_MST_RESET_MASK = 13'h02ff;

  typedef enum logic [1:0] {
    PDM_NORMAL     = 2'h0,
    PDM_SLEEP      = 2'h1,
    PDM_SW_STANDBY = 2'h2
  } pdm_mode_e;

  typedef enum logic [1:0] {
    PDM_WAKE_NONE  = 2'h0,
    PDM_WAKE_IRQ   = 2'h1,
    PDM_WAKE_NMI   = 2'h2,
    PDM_WAKE_RESET = 2'h3
  } pdm_cause_e;

endpackage

/* shared/pdm_reg_if.sv */
// Purpose: Register access path between the bus slave and the core.
// Assumes: wr_en is a one-cycle strobe; rdata is combinational.
// Notes:   The bus slave registers rdata before it reaches the bus.
`timescale 1ns/100ps
interface pdm_reg_if;
  logic       wr_en;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;

  modport bus_side (output wr_en, output addr, output wdata,
                    input rdata);
  modport reg_side (input wr_en, input addr, input wdata,
                    output rdata);
endinterface

/* test/pdm_power_ctrl_properties.sv */
// Purpose: Port-level assertions for the power-down controller.
// Assumes: One core clock domain; pins pass 2-stage synchronisers.
// Notes:   The mode is inferred from the halt and clock-stop outputs.
`timescale 1ns/100ps
module pdm_power_ctrl_properties
  import pdm_pkg::*;
(
  input wire logic                   I_CORE_CLK,
  input wire logic                   I_RESETN,
  input wire logic                   I_WB_CYC,
  input wire logic                   I_WB_STB,
  input wire logic [PDM_BUS_DW-1:0]  O_WB_DAT,
  input wire logic                   O_WB_ACK,
  input wire logic                   I_POWER_ON_RESET_IN_N,
  input wire logic                   I_MANUAL_RESET_IN_N,
  input wire logic                   I_NMI,
  input wire logic                   I_SLEEP_EXEC,
  input wire logic [PDM_N_UNITS-1:0] I_MODULE_STOP,
  input wire logic                   O_CPU_HALT,
  input wire logic                   O_CLOCK_GEN_STOP,
  input wire logic                   O_PORT_FLOAT,
  input wire logic [PDM_N_UNITS-1:0] O_UNIT_HOLD,
  input wire logic [PDM_N_UNITS-1:0] O_UNIT_RESET
);
  // A reset pin still in the synchroniser would override sleep entry
  logic [3:0] pins_up;
  always_ff @(posedge I_CORE_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      pins_up <= 4'h0;
    end else begin
      pins_up <= {pins_up[2:0],
                  I_POWER_ON_RESET_IN_N & I_MANUAL_RESET_IN_N};
    end
  end

  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_RESETN);

  chk_ack_follows: assert property (I_WB_CYC && I_WB_STB && !O_WB_ACK
    |=> O_WB_ACK) else $error("bus request not acknowledged");
  chk_ack_pulse: assert property (O_WB_ACK |=> !O_WB_ACK)
    else $error("ack longer than one cycle");
  chk_dat_upper: assert property (O_WB_DAT[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  chk_sleep_entry: assert property (I_SLEEP_EXEC && !O_CPU_HALT
    && (&pins_up) |=> O_CPU_HALT) else $error("sleep not entered");
  chk_standby_units: assert property (O_CLOCK_GEN_STOP |->
    O_CPU_HALT && ((O_UNIT_RESET & PDM_SWS_RESET_MASK) == PDM_SWS_RESET_MASK)
    && ((O_UNIT_HOLD & 13'h1500) == 13'h1500))
    else $error("standby unit state wrong");
  chk_float_needs: assert property (O_PORT_FLOAT |-> O_CLOCK_GEN_STOP)
    else $error("ports float outside standby");
  chk_float_port: assert property (O_CLOCK_GEN_STOP |->
    O_UNIT_HOLD[PDM_U_PORT] != O_PORT_FLOAT) else $error("port hold wrong");
  chk_mod_reset: assert property (!O_CLOCK_GEN_STOP &&
    !$past(O_CLOCK_GEN_STOP) |->
    O_UNIT_RESET == ($past(I_MODULE_STOP) & PDM_MST_RESET_MASK))
    else $error("module stop reset wrong");
  chk_mod_hold: assert property (!O_CLOCK_GEN_STOP &&
    !$past(O_CLOCK_GEN_STOP) |-> O_UNIT_HOLD == ($past(I_MODULE_STOP)
    & PDM_MST_HOLD_MASK & ~PDM_MST_RESET_MASK))
    else $error("module stop hold wrong");
  chk_nmi_wake: assert property ($rose(I_NMI) && O_CPU_HALT
    |-> ##[1:4] !O_CPU_HALT) else $error("nmi did not wake");

  cover property (I_SLEEP_EXEC && !O_CPU_HALT);
  cover property (O_PORT_FLOAT);
  cover property ($fell(O_CLOCK_GEN_STOP));
endmodule

bind pdm_power_ctrl pdm_power_ctrl_properties u_props (
  .I_CORE_CLK, .I_RESETN, .I_WB_CYC, .I_WB_STB, .O_WB_DAT, .O_WB_ACK,
  .I_POWER_ON_RESET_IN_N, .I_MANUAL_RESET_IN_N, .I_NMI, .I_SLEEP_EXEC,
  .I_MODULE_STOP, .O_CPU_HALT, .O_CLOCK_GEN_STOP, .O_PORT_FLOAT,
  .O_UNIT_HOLD, .O_UNIT_RESET);

/* test/testbench.sv */
// Purpose: Self-checking bench for the power-down controller.
// Assumes: Bus master waits for ack; pins settle within a few edges.
// Notes:   Register expectations are kept in a bench-side mirror.
`timescale 1ns/100ps
module testbench;
  import pdm_pkg::*;
  logic        clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0;
  logic        we = 1'b0, por_n = 1'b1, man_n = 1'b1, nmi = 1'b0;
  logic        slp = 1'b0, wd = 1'b0, ack, halt, cstop, flt;
  logic [7:0]  adr = 8'h00, irq = 8'h00, q, mirror, v;
  logic [3:0]  sel = 4'h0;
  logic [31:0] wdat = 32'h0, rdat;
  logic [12:0] mstop = 13'h0, hold, ures;
  int          seed, error_cnt = 0, tests_run = 0;
  logic [7:0]  cfg [2] = '{8'h9e, 8'hdd};
  int          blk [2] = '{7, 1};
  int          wak [2] = '{2, 6};

  pdm_power_ctrl u_dut (
    .I_CORE_CLK(clk), .I_RESETN(rst_n), .I_WB_CYC(cyc), .I_WB_STB(stb),
    .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(sel), .I_WB_DAT(wdat),
    .O_WB_DAT(rdat), .O_WB_ACK(ack), .I_POWER_ON_RESET_IN_N(por_n),
    .I_MANUAL_RESET_IN_N(man_n), .I_NMI(nmi),
    .I_EXTERNAL_INTERRUPT_LINES(irq), .I_SLEEP_EXEC(slp),
    .I_WATCHDOG_RUN_ENABLE(wd), .I_MODULE_STOP(mstop), .O_CPU_HALT(halt),
    .O_CLOCK_GEN_STOP(cstop), .O_PORT_FLOAT(flt), .O_UNIT_HOLD(hold),
    .O_UNIT_RESET(ures));

  initial begin
    forever #2.5 clk = ~clk;
  end

  task results;
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task give_up;
    error_cnt++;
    $display("CHECK FAILED at %0t: wait timed out", $time);
    results();
  endtask

  task chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d,
                    input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    wdat <= {24'h0, d};
    // Ack and read data are sampled at the rising edge, then released
    @(posedge clk);
    while (ack !== 1'b1 && n < 40) begin
      @(posedge clk);
      n++;
    end
    if (ack !== 1'b1) give_up();
    q = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task wr(input logic [7:0] d);
    wb(1'b1, PDM_ADDR_STANDBY_CONTROL, d, 4'h1);
  endtask

  task rd(input logic [7:0] a, input logic [7:0] e);
    wb(1'b0, a, 8'h00, 4'hf);
    chk(16'(q), 16'(e));
  endtask

  task automatic wait_halt(input logic e);
    int n;
    n = 0;
    while (halt !== e && n < 20) begin
      @(negedge clk);
      n++;
    end
    if (halt !== e) give_up();
  endtask

  task sleep_now;
    @(posedge clk);
    slp <= 1'b1;
    @(posedge clk);
    slp <= 1'b0;
    @(negedge clk);
  endtask

  // A refused 1 leaves the old bit in place rather than clearing it
  function automatic logic [7:0] exp_reg(input logic [7:0] old,
                                         input logic [7:0] d, input logic w);
    logic [7:0] e;
    e = (d & PDM_SBC_WRITABLE) | PDM_SBC_FIXED_ONES;
    if (w && d[7]) e[7] = old[7];
    if (w && d[6]) e[6] = old[6];
    return e;
  endfunction

  initial begin
    seed = 67034;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    chk(16'({halt, cstop, flt}), 16'h0);
    chk(16'(hold | ures), 16'h0);
    rd(PDM_ADDR_STANDBY_CONTROL, PDM_SBC_RESET);
    rd(8'h08, 8'h00);
    mirror = PDM_SBC_RESET;
    for (int i = 0; i < 10; i++) begin
      v = (i == 0) ? 8'hff : 8'($random(seed));
      @(posedge clk);
      wd <= v[5];
      wr(v);
      mirror = exp_reg(mirror, v, v[5]);
      rd(PDM_ADDR_STANDBY_CONTROL, mirror);
    end
    wb(1'b1, PDM_ADDR_STANDBY_CONTROL, ~mirror, 4'h0);
    wb(1'b1, 8'h08, ~mirror, 4'h1);
    rd(PDM_ADDR_STANDBY_CONTROL, mirror);
    @(posedge clk);
    wd <= 1'b0;
    wr(8'h1f);
    sleep_now;
    chk(16'({halt, cstop}), 16'h2);
    @(posedge clk);
    mstop <= 13'($random(seed));
    repeat (2) @(negedge clk);
    chk(16'(ures), 16'(mstop & PDM_MST_RESET_MASK));
    chk(16'(hold), 16'(mstop & 13'h0500));
    chk(16'(halt), 16'h1);
    @(posedge clk);
    mstop <= 13'h0;
    nmi <= 1'b1;
    wait_halt(1'b0);
    @(posedge clk);
    nmi <= 1'b0;
    rd(PDM_ADDR_STATUS, 8'({PDM_WAKE_NMI, PDM_NORMAL}));
    for (int i = 0; i < 2; i++) begin
      wr(cfg[i]);
      sleep_now;
      chk(16'({halt, cstop, flt}), 16'({2'b11, cfg[i][6]}));
      chk(16'(hold), 16'(PDM_SWS_HOLD_MASK &
          ~(13'(cfg[i][6]) << PDM_U_PORT)));
      chk(16'(ures), 16'(PDM_SWS_RESET_MASK));
      @(posedge clk);
      irq <= 8'h01 << blk[i];
      // Wake takes three edges from the pin; eight leaves margin
      repeat (8) @(negedge clk);
      chk(16'(halt), 16'h1);
      @(posedge clk);
      irq <= irq | (8'h01 << wak[i]);
      wait_halt(1'b0);
      @(posedge clk);
      irq <= 8'h00;
      chk(16'({cstop, flt}), 16'h0);
    end
    wr(8'h9f);
    sleep_now;
    @(posedge clk);
    man_n <= 1'b0;
    wait_halt(1'b0);
    @(posedge clk);
    man_n <= 1'b1;
    repeat (4) @(posedge clk);
    rd(PDM_ADDR_STANDBY_CONTROL, 8'h9f);
    por_n <= 1'b0;
    repeat (4) @(posedge clk);
    por_n <= 1'b1;
    repeat (4) @(posedge clk);
    rd(PDM_ADDR_STANDBY_CONTROL, PDM_SBC_RESET);
    results();
  end
endmodule
